/* File: rtl/port_pkg.sv */
// Constants and types shared by the port pin logic
package port_pkg;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int          PORT_WIDTH     = 8;
	localparam int          PORT_COUNT     = 4;
	localparam logic [7:0]  DIR_RESET      = 8'h00;
	localparam logic [7:0]  LATCH_RESET    = 8'h00;
	localparam logic [7:0]  READ_RESET     = 8'h00;

	// ----------------------------------------
	// Access kinds on the data register
	// ----------------------------------------
	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_WRITE,
		ACC_RMW
	} access_t;

	// ----------------------------------------
	// Operating modes
	// ----------------------------------------
	typedef enum logic {
		MODE_SINGLE_CHIP,
		MODE_EXT_BUS
	} chip_mode_t;

endpackage : port_pkg

/* File: rtl/port_alt_if.sv */
// Carrier for the pin ownership decision between the core and the mux
interface port_alt_if #(
	parameter int W = 8
);
	logic [W-1:0] gpio_owns;
	logic [W-1:0] core_oe;
	logic [W-1:0] core_out;
	logic [W-1:0] pad_oe;
	logic [W-1:0] pad_out;

	modport core (output gpio_owns, output core_oe, output core_out, input pad_oe, input pad_out);
	modport mux  (input gpio_owns, input core_oe, input core_out, output pad_oe, output pad_out);
endinterface : port_alt_if

/* File: rtl/port_alt_mux.sv */
// Chooses between plain port drive and alternate-function drive per pin
module port_alt_mux #(
	parameter int W = 8
) (
	port_alt_if.mux         pins,    // Core side
	input  wire logic [W-1:0] alt_oe,  // Alternate function drives, high
	input  wire logic [W-1:0] alt_out  // Alternate function output value
);
	// ----------------------------------------
	// Per-pin selection
	// ----------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_pin
		always_comb begin
			if (pins.gpio_owns[i]) begin
				pins.pad_oe[i]  = pins.core_oe[i];
				pins.pad_out[i] = pins.core_out[i];
			end else begin
				pins.pad_oe[i]  = alt_oe[i];
				pins.pad_out[i] = alt_out[i];
			end
		end
	end
endmodule : port_alt_mux

/* File: rtl/port_pins.sv */
// One bidirectional general-purpose port: direction, latch, pin read and alternate use
module port_pins
#(
	parameter int          W        = port_pkg::PORT_WIDTH,
	parameter int unsigned PORT_NUM = 0
) (
	input  wire logic                    ref_clk,     // System clock
	input  wire logic                    resetn,      // Asynchronous reset, low
	input  wire port_pkg::chip_mode_t    chip_mode,   // Operating mode
	input  wire logic                    dir_we,      // Direction register write strobe
	input  wire logic [W-1:0]            dir_wdata,   // Direction write data
	input  wire port_pkg::access_t       data_acc,    // Data register access kind
	input  wire logic [W-1:0]            data_wdata,  // Write data or modify value
	input  wire logic [W-1:0]            data_wmask,  // Bits targeted by modify
	input  wire logic                    data_re,     // Data register read strobe
	input  wire logic [W-1:0]            pin_in,      // Pin levels
	input  wire logic [W-1:0]            alt_oe,      // Alternate function enable
	input  wire logic [W-1:0]            alt_out,     // Alternate function value
	output logic      [W-1:0]            pin_out,     // Pin output value
	output logic      [W-1:0]            pin_oe_n,    // Output enable, low drives
	output logic      [W-1:0]            dir,         // Direction register
	output logic      [W-1:0]            pin_value_register // Read data
);
	import port_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [W-1:0] latch;
	logic [W-1:0] next_latch;
	logic [W-1:0] next_dir;
	logic [W-1:0] next_rd;
	logic [W-1:0] next_pin_out;
	logic [W-1:0] next_oe_n;
	logic         gpio_mode;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	// What software sees per bit: latch when output, pin level when input
	function automatic logic [W-1:0] seen_value(
		input logic [W-1:0] dir_bits,    // Direction bits
		input logic [W-1:0] latch_bits,  // Output latch
		input logic [W-1:0] pin_bits     // Pin levels
	);
		seen_value = (dir_bits & latch_bits) | (~dir_bits & pin_bits);
	endfunction : seen_value

	// ----------------------------------------
	// Pin ownership
	// ----------------------------------------
	// Alternate function takes any pin whose alt_oe bit is high
	port_alt_if #(.W(W)) alt_bus ();


	// Ports above three ignore chip_mode; there, or in single-chip mode, a pin stays plain I/O unless its alt_oe bit is high
	assign gpio_mode = (PORT_NUM > 3) || (chip_mode == MODE_SINGLE_CHIP);
	assign alt_bus.gpio_owns = gpio_mode ? ~alt_oe : {W{1'b0}};
	assign alt_bus.core_oe   = dir;
	assign alt_bus.core_out  = latch;

	port_alt_mux #(.W(W)) i_port_alt_mux (
		.pins    (alt_bus.mux),
		.alt_oe  (alt_oe),
		.alt_out (alt_out)
	);

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	// No guard against raising direction over a stale latch
	always_comb begin
		next_dir = dir_we ? dir_wdata : dir;
		next_latch = latch;
		unique case (data_acc)
			ACC_WRITE: next_latch = data_wdata;
			ACC_RMW:   next_latch = (data_wmask & data_wdata)
				| (~data_wmask & seen_value(dir, latch, pin_in));
			default:   next_latch = latch;
		endcase
		// Output pins read back the driven latch, inputs the pin
		next_rd = data_re ? seen_value(dir, latch, pin_in) : pin_value_register;
		next_pin_out = alt_bus.pad_out;
		next_oe_n = ~alt_bus.pad_oe;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dir                <= W'(DIR_RESET);
			latch              <= W'(LATCH_RESET);
			pin_value_register <= W'(READ_RESET);
			pin_out            <= W'(LATCH_RESET);
			pin_oe_n           <= ~W'(DIR_RESET);
		end else begin
			dir                <= next_dir;
			latch              <= next_latch;
			pin_value_register <= next_rd;
			pin_out            <= next_pin_out;
			pin_oe_n           <= next_oe_n;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Bit 0 spot checks, plus whole-word checks of the write latch and the bus-mode enables
	a_input_undriven: assert property (@(posedge ref_clk) disable iff (!resetn)
		(gpio_mode && !alt_oe[0] && !dir[0]) |=> pin_oe_n[0])
		else $error("input pin driven");
	a_output_drives: assert property (@(posedge ref_clk) disable iff (!resetn)
		(gpio_mode && !alt_oe[0] && dir[0]) |=> (!pin_oe_n[0] && pin_out[0] == $past(latch[0])))
		else $error("output pin not driving latch");
	a_write_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_acc == ACC_WRITE) |=> (latch == $past(data_wdata)))
		else $error("write not latched");
	a_read_output: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_re && dir[0]) |=> (pin_value_register[0] == $past(latch[0])))
		else $error("output read wrong");
	a_read_input: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_re && !dir[0]) |=> (pin_value_register[0] == $past(pin_in[0])))
		else $error("input read wrong");
	a_rmw_input: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_acc == ACC_RMW && !data_wmask[0] && !dir[0]) |=> (latch[0] == $past(pin_in[0])))
		else $error("rmw input bit not loaded");
	a_rmw_output: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_acc == ACC_RMW && !data_wmask[0] && dir[0]) |=> $stable(latch[0]))
		else $error("rmw output bit changed");
	a_input_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_acc == ACC_WRITE && !dir[0] && !dir_we && gpio_mode && !alt_oe[0])
			##1 (gpio_mode && !alt_oe[0]) |=> pin_oe_n[0])
		else $error("write drove input pin");
	a_ext_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
		(PORT_NUM <= 3 && chip_mode == MODE_EXT_BUS) |=> (pin_oe_n == ~$past(alt_oe)))
		else $error("gpio drove pin in bus mode");

	// Direction write, holding, mode and reset
	a_dir_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		dir_we |=> (dir == $past(dir_wdata)))
		else $error("direction write lost");

	a_reset_dir: assert property (@(posedge ref_clk)
		$rose(resetn) |-> (dir == W'(DIR_RESET) && pin_oe_n == ~W'(DIR_RESET)))
		else $error("pins not inputs after reset");

	a_rd_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		!data_re |=> $stable(pin_value_register))
		else $error("read data changed without read");

	a_latch_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		(data_acc == ACC_NONE) |=> $stable(latch))
		else $error("latch changed without access");

	a_ext_value: assert property (@(posedge ref_clk) disable iff (!resetn)
		(PORT_NUM <= 3 && chip_mode == MODE_EXT_BUS) |=> (pin_out == $past(alt_out)))
		else $error("bus mode pin value not alternate");

	// ----------------------------------------
	// Per-bit checks
	// ----------------------------------------
	// Every bit, not only bit 0
	for (genvar b = 0; b < W; b++) begin : g_bit_check
		// Drive, ownership and direction write
		a_bit_undriven: assert property (@(posedge ref_clk) disable iff (!resetn)
			(gpio_mode && !alt_oe[b] && !dir[b]) |=> pin_oe_n[b])
			else $error("input bit driven");

		a_bit_drives: assert property (@(posedge ref_clk) disable iff (!resetn)
			(gpio_mode && !alt_oe[b] && dir[b]) |=> (!pin_oe_n[b] && pin_out[b] == $past(latch[b])))
			else $error("output bit not driving latch");

		a_bit_alt_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
			alt_oe[b] |=> (!pin_oe_n[b] && pin_out[b] == $past(alt_out[b])))
			else $error("alternate function not driving");

		a_bit_bus_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
			(PORT_NUM <= 3 && chip_mode == MODE_EXT_BUS && !alt_oe[b]) |=> pin_oe_n[b])
			else $error("gpio bit driven in bus mode");

		a_bit_dir_write: assert property (@(posedge ref_clk) disable iff (!resetn)
			dir_we |=> (dir[b] == $past(dir_wdata[b])))
			else $error("direction bit write lost");

		// Latch updates
		a_bit_rmw_target: assert property (@(posedge ref_clk) disable iff (!resetn)
			(data_acc == ACC_RMW && data_wmask[b]) |=> (latch[b] == $past(data_wdata[b])))
			else $error("rmw target bit wrong");

		a_bit_rmw_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
			(data_acc == ACC_RMW && !data_wmask[b] && dir[b]) |=> $stable(latch[b]))
			else $error("rmw output bit changed");

		a_bit_rmw_load: assert property (@(posedge ref_clk) disable iff (!resetn)
			(data_acc == ACC_RMW && !data_wmask[b] && !dir[b]) |=> (latch[b] == $past(pin_in[b])))
			else $error("rmw input bit not loaded");

		a_bit_input_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
			(data_acc == ACC_WRITE && !dir[b]) |=> (latch[b] == $past(data_wdata[b])))
			else $error("input bit latch not written");

		// Read-back
		a_bit_read_out: assert property (@(posedge ref_clk) disable iff (!resetn)
			(data_re && dir[b]) |=> (pin_value_register[b] == $past(latch[b])))
			else $error("output bit read wrong");

		a_bit_read_in: assert property (@(posedge ref_clk) disable iff (!resetn)
			(data_re && !dir[b]) |=> (pin_value_register[b] == $past(pin_in[b])))
			else $error("input bit read wrong");
	end
endmodule : port_pins

/* File: testbench/pin_model.sv */
// Pad model: resolves each pad level from the port drive and an outside source
module pin_model (
	input  wire logic [7:0] pin_out,  // Port drive value
	input  wire logic [7:0] pin_oe_n, // Port drive enable, low
	input  wire logic [7:0] ext_val,  // Outside source value
	input  wire logic [7:0] ext_en,   // Outside source active
	output logic      [7:0] level     // Resolved pad level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Floating pads show the opposite of the port value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) level[i] = pin_out[i];
			else if (ext_en[i]) level[i] = ext_val[i];
			else level[i] = ~pin_out[i];
		end
	end
endmodule : pin_model

/* File: testbench/tb_bidirectional_port_pin_logic.sv */
// Self-checking bench for the port pin logic
module tb_bidirectional_port_pin_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import port_pkg::*;
	logic       ref_clk = 1'b0, resetn = 1'b0, dir_we = 1'b0, data_re = 1'b0;
	chip_mode_t chip_mode = MODE_SINGLE_CHIP;
	access_t    data_acc = ACC_NONE;
	logic [7:0] dir_wdata = 8'h00, data_wdata = 8'h00, data_wmask = 8'h00;
	logic [7:0] alt_oe = 8'h00, alt_out = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
	logic [7:0] level, pin_out, pin_oe_n, dir, rdata, v;
	int         n_mismatch = 0, n_compared = 0;
	always #5 ref_clk = ~ref_clk;
	port_pins #(.W(8), .PORT_NUM(0)) i_port_pins (.ref_clk(ref_clk), .resetn(resetn), .chip_mode(chip_mode),
		.dir_we(dir_we), .dir_wdata(dir_wdata), .data_acc(data_acc), .data_wdata(data_wdata),
		.data_wmask(data_wmask), .data_re(data_re), .pin_in(level), .alt_oe(alt_oe), .alt_out(alt_out),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .dir(dir), .pin_value_register(rdata));
	pin_model i_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en),
		.level(level));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input access_t k, input logic [7:0] d, input logic [7:0] m);
		@(negedge ref_clk);
		data_acc = k;
		data_wdata = d;
		data_wmask = m;
		@(negedge ref_clk);
		data_acc = ACC_NONE;
	endtask : acc
	task automatic set_dir(input logic [7:0] d);
		@(negedge ref_clk);
		dir_we = 1'b1;
		dir_wdata = d;
		@(negedge ref_clk);
		dir_we = 1'b0;
	endtask : set_dir
	task automatic rd(output logic [7:0] r);
		repeat (2) @(negedge ref_clk);
		data_re = 1'b1;
		@(negedge ref_clk);
		data_re = 1'b0;
		r = rdata;
	endtask : rd
	task automatic t_input;
		ext_en = 8'hff;
		ext_val = 8'h33;
		acc(ACC_WRITE, 8'h5a, 8'h00);
		rd(v);
		chk(pin_oe_n, 8'hff);
		chk(v, 8'h33);
	endtask : t_input
	task automatic t_output;
		ext_en = 8'h00;
		set_dir(8'hff);
		rd(v);
		chk(pin_oe_n, 8'h00);
		chk(pin_out, 8'h5a);
		chk(v, 8'h5a);
	endtask : t_output
	task automatic t_rmw;
		set_dir(8'h0f);
		ext_en = 8'hf0;
		ext_val = 8'h3c;
		acc(ACC_RMW, 8'h01, 8'h01);
		set_dir(8'hff);
		rd(v);
		chk(pin_out, 8'h3b);
		chk(v, 8'h3b);
	endtask : t_rmw
	task automatic t_alt;
		set_dir(8'hff);
		chip_mode = MODE_EXT_BUS;
		alt_oe = 8'hf0;
		alt_out = 8'hc3;
		repeat (3) @(negedge ref_clk);
		chk(pin_oe_n, 8'h0f);
		chk(pin_out & 8'hf0, 8'hc0);
		chip_mode = MODE_SINGLE_CHIP;
		repeat (3) @(negedge ref_clk);
		chk(pin_oe_n, 8'h00);
		chk(pin_out, 8'hcb);
	endtask : t_alt
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (16) @(negedge ref_clk);
		chk(dir, 8'h00);
		chk(pin_oe_n, 8'hff);
		resetn = 1'b1;
		t_input();
		t_output();
		t_rmw();
		t_alt();
		report_and_stop();
	end
	initial begin
		#20000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb_bidirectional_port_pin_logic
